// File: hw/asp_pkg.sv
// package: constants and types for the converter sample output port
package asp_pkg;
  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int ASP_DATA_W = 10;
  localparam int ASP_LATENCY_CYC = 6;
  localparam int ASP_WAKE_CYC = 20;
  localparam int ASP_FIFO_DEPTH = 8;
  localparam logic [9:0] ASP_MID_CODE = 10'h200;
  localparam logic [9:0] ASP_DATA_RST = 10'h000;
  // ---------------------------------------------------------------
  // range select levels
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ASP_RANGE_1V0 = 2'h0,
    ASP_RANGE_1V5 = 2'h1,
    ASP_RANGE_2V0 = 2'h3
  } asp_range_e;
  // power state, gray along off -> wake -> run
  typedef enum logic [1:0] {
    ASP_ST_OFF = 2'h0,
    ASP_ST_WAKE = 2'h1,
    ASP_ST_RUN = 2'h3
  } asp_state_e;
  // sample word travelling through the pipeline; only its code enters the fifo
  typedef struct packed {
    logic valid;
    logic [9:0] code;
  } asp_word_s;
endpackage

// File: hw/asp_fifo.sv
// file: parameterised valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk, // clock
  input wire logic reset, // async reset, high
  input wire logic flush, // drop all content
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // not empty
  input wire logic out_ready, // reader takes word
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  // handshake terms
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // asp_fifo
`default_nettype wire

// File: hw/asp_core.sv
// file: digital side of the pipelined 10-bit converter output port
`timescale 1ns/1ps
`default_nettype none
module asp_core
  import asp_pkg::*;
#(
  parameter int DATA_W = ASP_DATA_W,
  parameter int LATENCY = ASP_LATENCY_CYC,
  parameter int WAKE = ASP_WAKE_CYC,
  parameter int DEPTH = ASP_FIFO_DEPTH
) (
  input wire logic clk, // sampling clock
  input wire logic reset, // async reset, high
  input wire logic [DATA_W-1:0] sample_code, // quantiser result, offset binary
  input wire logic power_down_request, // pin, high = standby
  input wire logic output_format_select, // pin, high = two's complement
  input wire logic [1:0] input_range_select, // pin level code
  output logic [DATA_W-1:0] data_out, // output word
  output logic data_valid, // head word is valid
  input wire logic data_ready, // capture takes word
  output logic sample_ready, // fifo accepting samples
  output asp_range_e range_active, // decoded span
  output logic powered_down // standby state
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // wake counter wide enough for the whole interval
  localparam int WAKE_W = $clog2(WAKE + 1);
  // synchroniser flops
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic [1:0] rng_meta_q;
  logic [1:0] rng_sync_q;
  logic pd;
  logic fmt;
  // power state
  asp_state_e state_q;
  logic [WAKE_W-1:0] wake_q;
  // pipeline stages
  asp_word_s pipe_q [LATENCY];
  asp_word_s head;
  // buffer and output stage
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic out_valid_q;
  // standby and format pins; standby reads as asserted until seen twice
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_meta_q <= 2'h1;
      pin_sync_q <= 2'h1;
    end else begin
      pin_meta_q <= {output_format_select, power_down_request};
      pin_sync_q <= pin_meta_q;
    end
  end
  // range pin, two flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rng_meta_q <= 2'h0;
      rng_sync_q <= 2'h0;
    end else begin
      rng_meta_q <= input_range_select;
      rng_sync_q <= rng_meta_q;
    end
  end
  assign pd = pin_sync_q[0];
  assign fmt = pin_sync_q[1];
  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // two's complement is offset binary with the msb inverted
  function automatic logic [DATA_W-1:0] fmt_word(input logic [DATA_W-1:0] code, input logic twos);
    if (twos) begin
      fmt_word = code ^ DATA_W'(ASP_MID_CODE);
    end else begin
      fmt_word = code;
    end
  endfunction
  // pin level code to span; the one unused code, 2'h2, reads as ASP_RANGE_1V0, like 2'h0
  function automatic asp_range_e range_of(input logic [1:0] lvl);
    unique case (lvl)
      2'h3: range_of = ASP_RANGE_2V0;
      2'h1: range_of = ASP_RANGE_1V5;
      default: range_of = ASP_RANGE_1V0;
    endcase
  endfunction
  // ---------------------------------------------------------------
  // range decode
  // ---------------------------------------------------------------
  // span from pin level
  // registered so the span changes only on a clock edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      range_active <= ASP_RANGE_1V0;
    end else begin
      range_active <= range_of(rng_sync_q);
    end
  end
  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  // standby and wake sequencing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ASP_ST_OFF;
    end else if (pd) begin
      state_q <= ASP_ST_OFF;
    end else begin
      unique case (state_q)
        // leaving standby always passes through the wake interval
        ASP_ST_OFF: state_q <= ASP_ST_WAKE;
        ASP_ST_WAKE: begin
          if (wake_q == WAKE_W'(WAKE - 1)) begin
            state_q <= ASP_ST_RUN;
          end
        end
        ASP_ST_RUN: state_q <= ASP_ST_RUN;
        default: state_q <= ASP_ST_OFF;
      endcase
    end
  end
  // wake-up interval count, idle outside the wake state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_q <= '0;
    end else if (pd || (state_q != ASP_ST_WAKE)) begin
      wake_q <= '0;
    end else begin
      wake_q <= wake_q + WAKE_W'(1);
    end
  end
  // ---------------------------------------------------------------
  // status
  // ---------------------------------------------------------------
  // standby flag straight from the state register
  assign powered_down = (state_q == ASP_ST_OFF);
  // ---------------------------------------------------------------
  // conversion pipeline
  // ---------------------------------------------------------------
  // one word per cycle, fixed latency
  // stages shift only while the buffer accepts, so nothing is lost
  // codes are zeroed, not only flagged, so no stale word can surface
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (pd) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (sample_ready) begin
      pipe_q[0] <= '{valid: (state_q == ASP_ST_RUN), code: sample_code};
      for (int i = 1; i < LATENCY; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end
  assign head = pipe_q[LATENCY-1];
  // ---------------------------------------------------------------
  // output buffer
  // ---------------------------------------------------------------
  // absorbs capture back-pressure; when full the pipeline holds
  // and no quantiser result is taken until room returns
  asp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .flush(pd),
    .in_valid(head.valid),
    .in_ready(sample_ready),
    .in_data(head.code),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );
  // ---------------------------------------------------------------
  // output register stage
  // ---------------------------------------------------------------
  // head word moves out when the output register is empty or taken
  assign fifo_pop = fifo_valid && (!out_valid_q || data_ready);
  // valid flag, cleared by standby; the word stands until taken
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid_q <= 1'b0;
    end else if (pd) begin
      out_valid_q <= 1'b0;
    end else if (!out_valid_q || data_ready) begin
      out_valid_q <= fifo_valid;
    end
  end
  // flag and word load at the same edge, so capture sees them together
  assign data_valid = out_valid_q && !pd;
  // format applied as the word is loaded
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_out <= ASP_DATA_RST;
    end else if (pd) begin
      // standby word held at zero, flagged invalid
      data_out <= ASP_DATA_RST;
    end else if (fifo_pop) begin
      data_out <= fmt_word(fifo_data, fmt);
    end
  end
endmodule // asp_core
`default_nettype wire

// File: tb/asp_core_asserts.sv
// checker: port assertions for the sample output port
`timescale 1ns/1ps
`default_nettype none
module asp_core_asserts
  import asp_pkg::*;
#(parameter int WAKE = 20, parameter int LATENCY = 6) (
  input wire logic clk, // clock
  input wire logic reset, // async reset
  input wire logic power_down_request, // standby pin
  input wire logic [1:0] input_range_select, // span pin
  input wire logic [9:0] data_out, // word
  input wire logic data_valid, // word valid
  input wire logic data_ready, // pop
  input wire logic sample_ready, // not full
  input wire asp_range_e range_active, // span
  input wire logic powered_down // standby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // cycles out of standby, saturating
  logic [5:0] awake_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) awake_q <= 6'h00;
    else if (powered_down) awake_q <= 6'h00;
    else if (awake_q != 6'h3F) awake_q <= awake_q + 6'h01;
  end
  pd_enter_a: assert property (power_down_request [*4] |-> powered_down)
    else $error("standby not entered");
  pd_valid_a: assert property (powered_down |-> !data_valid)
    else $error("valid during standby");
  pd_zero_a: assert property (powered_down |-> data_out == ASP_DATA_RST)
    else $error("word during standby");
  wake_gap_a: assert property (data_valid |-> awake_q >= WAKE + LATENCY - 1)
    else $error("valid before wake-up ends");
  valid_hold_a: assert property ((!power_down_request) [*4] ##0 (data_valid && !data_ready) |=> data_valid)
    else $error("unpopped word lost");
  range_2v0_a: assert property ((input_range_select == 2'h3) [*4] |-> range_active == ASP_RANGE_2V0)
    else $error("span not 2.0");
  range_1v5_a: assert property ((input_range_select == 2'h1) [*4] |-> range_active == ASP_RANGE_1V5)
    else $error("span not 1.5");
  range_1v0_a: assert property ((input_range_select[0] == 1'b0) [*4] |-> range_active == ASP_RANGE_1V0)
    else $error("span not 1.0");
  fill_c: cover property (!sample_ready);
  wake_c: cover property ($fell(powered_down));
  pop_c: cover property (data_valid && data_ready);
endmodule // asp_core_asserts
bind asp_core asp_core_asserts #(.WAKE(WAKE), .LATENCY(LATENCY)) u_asp_core_asserts (.clk(clk), .reset(reset),
  .power_down_request(power_down_request), .input_range_select(input_range_select), .data_out(data_out),
  .data_valid(data_valid), .data_ready(data_ready), .sample_ready(sample_ready), .range_active(range_active),
  .powered_down(powered_down));
`default_nettype wire

// File: tb/asp_capture.sv
// capture model: pops and registers words on the rising edge
`timescale 1ns/1ps
`default_nettype none
module asp_capture (
  input wire logic clk, // sampling clock
  input wire logic enable, // bench allows pops
  input wire logic [9:0] data_out, // converter word
  input wire logic data_valid, // word valid
  output logic data_ready, // pop request
  output logic [9:0] last_q // last valid word
);
  initial data_ready = 1'b0;
  // pop request changes off the sampling edge
  always @(negedge clk) data_ready <= enable;
  always_ff @(posedge clk) if (data_valid && data_ready) last_q <= data_out;
endmodule // asp_capture
`default_nettype wire

// File: tb/adc_sample_output_port_bench.sv
// bench: self-checking scenarios for the converter sample output port
`timescale 1ns/1ps
`default_nettype none
module adc_sample_output_port_bench;
  import asp_pkg::*;
  logic clk = 1'b0, reset = 1'b1, en = 1'b1, power_down_request = 1'b0, output_format_select = 1'b0;
  logic clk_hold = 1'b0;
  logic [9:0] sample_code = 10'h000;
  logic [1:0] input_range_select = 2'h0;
  logic [9:0] data_out, last_q;
  logic data_valid, data_ready, sample_ready, powered_down;
  asp_range_e range_active;
  int num_errors = 0, n_tests = 0, cyc = 0;
  // clock runs except where standby lets the bench park it
  always #5 if (!clk_hold) clk = ~clk;
  asp_core u_asp_core (.clk(clk), .reset(reset), .sample_code(sample_code), .power_down_request(power_down_request),
    .output_format_select(output_format_select), .input_range_select(input_range_select), .data_out(data_out),
    .data_valid(data_valid), .data_ready(data_ready), .sample_ready(sample_ready), .range_active(range_active),
    .powered_down(powered_down));
  asp_capture u_asp_capture (.clk(clk), .enable(en), .data_out(data_out), .data_valid(data_valid),
    .data_ready(data_ready), .last_q(last_q));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_format(input logic fmt, input logic [9:0] code, input logic [9:0] exp);
    output_format_select = fmt;
    sample_code = code;
    wait_cyc(30);
    chk(last_q, exp);
  endtask
  task automatic t_range();
    asp_range_e tbl [4] = '{ASP_RANGE_1V0, ASP_RANGE_1V5, ASP_RANGE_1V0, ASP_RANGE_2V0};
    for (int i = 0; i < 4; i++) begin
      input_range_select = 2'(i);
      wait_cyc(5);
      chk(10'(range_active), 10'(tbl[i]));
    end
  endtask
  task automatic t_fill();
    en = 1'b0;
    wait_cyc(30);
    chk({9'h000, sample_ready}, 10'h000);
    en = 1'b1;
    wait_cyc(30);
    chk({9'h000, sample_ready}, 10'h001);
  endtask
  task automatic t_power();
    int seen;
    seen = 0;
    power_down_request = 1'b1;
    wait_cyc(5);
    sample_code = 10'h0CC;
    chk({9'h000, powered_down}, 10'h001);
    chk({9'h000, data_valid}, 10'h000);
    // clock parked low while standby holds
    clk_hold = 1'b1;
    #52;
    clk_hold = 1'b0;
    wait_cyc(2);
    chk({9'h000, powered_down}, 10'h001);
    power_down_request = 1'b0;
    while (data_valid !== 1'b1 && seen < 100) begin
      wait_cyc(1);
      seen++;
    end
    chk({9'h000, seen >= 20 && seen < 100}, 10'h001);
    chk(data_out, 10'h0CC);
    wait_cyc(2);
    chk(last_q, 10'h0CC);
  endtask
  initial begin
    wait_cyc(12);
    reset = 1'b0;
    wait_cyc(40);
    t_format(1'b0, 10'h1FF, 10'h1FF);
    t_format(1'b0, 10'h200, 10'h200);
    t_format(1'b1, 10'h200, 10'h000);
    t_format(1'b1, 10'h1FF, 10'h3FF);
    t_format(1'b0, 10'h2A5, 10'h2A5);
    t_range();
    t_fill();
    t_power();
    print_verdict();
  end
  // cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      print_verdict();
    end
  end
endmodule // adc_sample_output_port_bench
`default_nettype wire
